/* File: hdl/ocp_pkg.sv */
// Package with register map, field layout and timing constants of the over-current protection control block.
package ocp_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [2:0] OCP_ADDR_MODE = 3'h0;    // Protection mode control.
    localparam logic [2:0] OCP_ADDR_GAIN = 3'h1;    // Gain and filter control.
    localparam logic [2:0] OCP_ADDR_THR = 3'h2;     // Threshold code.
    localparam logic [2:0] OCP_ADDR_ATRIM = 3'h3;   // Amplifier offset trim.
    localparam logic [2:0] OCP_ADDR_CTRIM = 3'h4;   // Comparator offset trim.
    localparam logic [2:0] OCP_ADDR_MISC = 3'h5;    // Miscellaneous sense control.
    localparam logic [2:0] OCP_ADDR_IRQ = 3'h6;     // Interrupt flag and enable.

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int OCP_MODE_LSB = 6;        // Mode field occupies bits 7:6.
    localparam int OCP_STAT_BIT = 7;        // Protection output status bit.
    localparam int OCP_GAIN_LSB = 3;        // Gain code occupies bits 5:3.
    localparam int OCP_FLT_LSB = 0;         // Filter code occupies bits 2:0.
    localparam int OCP_ATRIM_MODE_BIT = 7;  // Amplifier trim mode.
    localparam int OCP_ATRIM_REF_BIT = 6;   // Amplifier trim reference select.
    localparam int OCP_CRB_BIT = 7;         // Calibration readback.
    localparam int OCP_CTRIM_MODE_BIT = 6;  // Comparator trim mode.
    localparam int OCP_CTRIM_REF_BIT = 5;   // Comparator trim reference select.
    localparam int OCP_DACREF_BIT = 6;      // DAC reference source select.
    localparam int OCP_IRQF_BIT = 4;        // Interrupt request flag.
    localparam int OCP_IRQE_BIT = 1;        // Interrupt enable.

    // ----------------------------------------------------------------
    // Reset values and mode codes
    // ----------------------------------------------------------------
    localparam logic [7:0] OCP_RST_BYTE = 8'h00;    // All registers reset to zero.
    localparam logic [1:0] OCP_MODE_OFF = 2'h0;     // Protection disabled.
    localparam logic [1:0] OCP_MODE_NINV = 2'h1;    // Non-inverting amplifier.
    localparam logic [1:0] OCP_MODE_INV = 2'h2;     // Inverting amplifier.
    localparam logic [1:0] OCP_MODE_CAL = 2'h3;     // Zero-volt input calibration.
    localparam logic [2:0] OCP_GAIN_UNITY = 3'h0;   // Gain code giving unity buffer.
    localparam logic [2:0] OCP_FLT_NONE = 3'h0;     // Filter bypass code.

    // ----------------------------------------------------------------
    // Filter timing
    // ----------------------------------------------------------------
    localparam int OCP_FLT_DIV = 4;         // Filter tick is crystal clock over four.
    localparam logic [1:0] OCP_DIV_LAST = 2'(OCP_FLT_DIV - 1);  // Last divider count.

endpackage : ocp_pkg

/* File: hdl/ocp_ctrl.sv */
// Over-current protection control: registers, mode switches, debounce filter and status.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Mode 00 disables, closes S1 S3.
// - Mode 01 non-inverting, closes S0 S3.
// - Mode 10 inverting, closes S1 S2.
// - Mode 11 calibration, closes S1 S3.
// - Disabled powers analog off, comparator low.
// - Gain code selects amplifier gain step.
// - Non-inverting with gain 000 opens S2 S3.
// - Comparator high means sense exceeds threshold.
// - Filter code sets debounce length.
// - Filter ticks at crystal clock over four.
// - Protection output blocks PWM, raises interrupt.
// - Protection output readable at gain register bit 7.
// - Threshold code drives the DAC.
// - DAC reference bit picks supply or internal.
// - Amplifier trim mode bit and 6-bit trim.
// - Reference select bits pick trim input.
// - Comparator trim mode bit and 5-bit trim.
// - Readback shows amplifier or comparator output.
// - Mode register low bits read zero.
// - Event sets flag bit 4, enable bit 1.
module ocp_ctrl
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Register port.
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Analog feedback.
    input wire logic raw_cmp_result_i,
    input wire logic amp_out_status_i,
    // Analog controls.
    output logic [3:0] mode_switch_o,
    output logic analog_enable_o,
    output logic [2:0] amp_gain_code_o,
    output logic amp_inverting_o,
    output logic [7:0] threshold_code_o,
    output logic dac_ref_source_sel_o,
    output logic amp_trim_mode_o,
    output logic amp_trim_ref_sel_o,
    output logic [5:0] amp_trim_value_o,
    output logic cmp_trim_mode_o,
    output logic cmp_trim_ref_sel_o,
    output logic [4:0] cmp_trim_value_o,
    // Protection results.
    output logic protect_out_o,
    output logic pwm_block_o,
    output logic protect_irq_o
);
    import ocp_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed
    {
        logic [1:0] mode;           // Protection mode field.
        logic [2:0] gain;           // Amplifier gain code.
        logic [2:0] flt;            // Debounce select.
        logic [7:0] thr;            // Threshold code.
        logic [7:0] atrim;          // Amplifier trim register.
        logic [6:0] ctrim;          // Comparator trim register, writable bits.
        logic dacref;               // DAC reference source.
        logic irq_flag;             // Sticky interrupt request.
        logic irq_en;               // Interrupt enable.
        logic [1:0] cmp_sync;       // Comparator synchronizer.
        logic [1:0] amp_sync;       // Amplifier status synchronizer.
        logic [1:0] div;            // Filter tick divider.
        logic [7:0] cnt;            // Debounce count.
        logic prot;                 // Filtered protection output.
        logic prot_prev;            // Previous output for edge detect.
        logic [3:0] sw;             // Switch drive.
        logic en;                   // Analog enable.
        logic inv;                  // Inverting amplifier selected.
        logic [7:0] rdata;          // Read data.
    } ocp_state_t;

    ocp_state_t st_q;   // Registered state.
    ocp_state_t st_d;   // Next state.

    // ----------------------------------------------------------------
    // Switch sets
    // ----------------------------------------------------------------
    // Switch drive is {S3, S2, S1, S0}; a one closes the switch.
    localparam logic [3:0] OCP_SW_S1_S3 = 4'ha;  // Off and calibration set.
    localparam logic [3:0] OCP_SW_S0_S3 = 4'h9;  // Non-inverting set.
    localparam logic [3:0] OCP_SW_S0 = 4'h1;     // Unity buffer: S2 and S3 open.
    localparam logic [3:0] OCP_SW_S1_S2 = 4'h6;  // Inverting set.

    // Number of filter ticks a level must stand; code 000 gives zero.
    function automatic logic [7:0] ocp_flt_len(input logic [2:0] code);
        ocp_flt_len = 8'((9'h1 << code) - 9'h1);
    endfunction : ocp_flt_len

    // Switch drive S3..S0 for a mode and gain code.
    function automatic logic [3:0] ocp_switches(input logic [1:0] m, input logic [2:0] g);
        logic [3:0] s;
        s = 4'h0;
        case (m)
            // Off: the stage sits idle on S1 and S3.
            OCP_MODE_OFF:
            begin
                s = OCP_SW_S1_S3;
            end
            // Non-inverting: the sense input feeds the positive input.
            OCP_MODE_NINV:
            begin
                s = OCP_SW_S0_S3;
                // Gain code 000 turns the stage into a plain buffer.
                if (g == OCP_GAIN_UNITY)
                begin
                    s = OCP_SW_S0;
                end
            end
            // Inverting: the sense input feeds the negative input.
            OCP_MODE_INV:
            begin
                s = OCP_SW_S1_S2;
            end
            // Calibration: zero-volt input, same set as off.
            default:
            begin
                s = OCP_SW_S1_S3;
            end
        endcase
        ocp_switches = s;
    endfunction : ocp_switches

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // Register writes, synchronizers, debounce filter and read mux.
    always_comb
    begin
        logic cmp_s;
        logic stable;
        logic event_set;
        logic readback;
        cmp_s = 1'b0;
        stable = 1'b0;
        event_set = 1'b0;
        readback = 1'b0;
        // Every field holds unless a branch below changes it.
        st_d = st_q;

        // Two-flop synchronizers; only the second stage is read downstream.
        st_d.cmp_sync = {st_q.cmp_sync[0], raw_cmp_result_i};
        st_d.amp_sync = {st_q.amp_sync[0], amp_out_status_i};

        // Comparator is forced low while disabled; high means over-current.
        cmp_s = st_q.cmp_sync[1] & (st_q.mode != OCP_MODE_OFF);

        // Filter tick divider.
        st_d.div = st_q.div + 2'h1;

        // Debounce: count ticks while input differs from output.
        if (st_q.mode == OCP_MODE_OFF)
        begin
            // Disabled: hold the filter cleared and the output low.
            st_d.cnt = 8'h00;
            st_d.prot = 1'b0;
            st_d.div = 2'h0;
        end
        // Input agrees with the output: restart the count.
        else if (cmp_s == st_q.prot)
        begin
            st_d.cnt = 8'h00;
        end
        // Filter bypassed: follow the input on the next edge.
        else if (st_q.flt == OCP_FLT_NONE)
        begin
            st_d.prot = cmp_s;
        end
        // Count once per filter tick while the new level holds.
        else if (st_q.div == OCP_DIV_LAST)
        begin
            // The count plus this tick against the selected length.
            stable = (st_q.cnt + 8'h01) >= ocp_flt_len(st_q.flt);
            if (stable)
            begin
                st_d.prot = cmp_s;
                st_d.cnt = 8'h00;
            end
            else
            begin
                // Not long enough yet: count this tick.
                st_d.cnt = st_q.cnt + 8'h01;
            end
        end
        // Remember the output for the edge detector.
        st_d.prot_prev = st_q.prot;

        // Rising protection output sets the sticky flag.
        event_set = st_q.prot & ~st_q.prot_prev;

        // Register writes.
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                // Mode field; the low bits do not exist.
                OCP_ADDR_MODE:
                begin
                    st_d.mode = reg_wdata_i[OCP_MODE_LSB +: 2];
                end
                // Gain and filter codes; the status bit is read-only.
                OCP_ADDR_GAIN:
                begin
                    st_d.gain = reg_wdata_i[OCP_GAIN_LSB +: 3];
                    st_d.flt = reg_wdata_i[OCP_FLT_LSB +: 3];
                end
                // Threshold code for the DAC.
                OCP_ADDR_THR:
                begin
                    st_d.thr = reg_wdata_i;
                end
                // Amplifier trim mode, reference and value.
                OCP_ADDR_ATRIM:
                begin
                    st_d.atrim = reg_wdata_i;
                end
                // Comparator trim; the readback bit is read-only.
                OCP_ADDR_CTRIM:
                begin
                    st_d.ctrim = reg_wdata_i[6:0];
                end
                // DAC reference source.
                OCP_ADDR_MISC:
                begin
                    st_d.dacref = reg_wdata_i[OCP_DACREF_BIT];
                end
                // Interrupt enable and flag; writing zero clears the flag.
                OCP_ADDR_IRQ:
                begin
                    st_d.irq_en = reg_wdata_i[OCP_IRQE_BIT];
                    st_d.irq_flag = reg_wdata_i[OCP_IRQF_BIT];
                end
                // Unmapped index: the write is dropped.
                default:
                begin
                    st_d.mode = st_q.mode;
                end
            endcase
        end
        // Hardware set wins over a software clear in the same cycle.
        if (event_set)
        begin
            st_d.irq_flag = 1'b1;
        end

        // Calibration readback from the selected source.
        // With neither trim mode set the bit reads zero.
        if (st_q.atrim[OCP_ATRIM_MODE_BIT])
        begin
            readback = st_q.amp_sync[1];
        end
        else if (st_q.ctrim[OCP_CTRIM_MODE_BIT])
        begin
            readback = st_q.cmp_sync[1];
        end

        // Read data, valid the cycle after the strobe only.
        st_d.rdata = OCP_RST_BYTE;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                // Mode field in the top bits; the rest reads zero.
                OCP_ADDR_MODE:
                begin
                    st_d.rdata[OCP_MODE_LSB +: 2] = st_q.mode;
                end
                // Status, gain and filter codes; bit 6 reads zero.
                OCP_ADDR_GAIN:
                begin
                    st_d.rdata[OCP_STAT_BIT] = st_q.prot;
                    st_d.rdata[OCP_GAIN_LSB +: 3] = st_q.gain;
                    st_d.rdata[OCP_FLT_LSB +: 3] = st_q.flt;
                end
                // Threshold code.
                OCP_ADDR_THR:
                begin
                    st_d.rdata = st_q.thr;
                end
                // Amplifier trim register.
                OCP_ADDR_ATRIM:
                begin
                    st_d.rdata = st_q.atrim;
                end
                // Comparator trim with the readback bit on top.
                OCP_ADDR_CTRIM:
                begin
                    st_d.rdata[6:0] = st_q.ctrim;
                    st_d.rdata[OCP_CRB_BIT] = readback;
                end
                // DAC reference source only.
                OCP_ADDR_MISC:
                begin
                    st_d.rdata[OCP_DACREF_BIT] = st_q.dacref;
                end
                // Interrupt flag and enable.
                OCP_ADDR_IRQ:
                begin
                    st_d.rdata[OCP_IRQF_BIT] = st_q.irq_flag;
                    st_d.rdata[OCP_IRQE_BIT] = st_q.irq_en;
                end
                // Unmapped index reads zero.
                default:
                begin
                    st_d.rdata = OCP_RST_BYTE;
                end
            endcase
        end

        // Registered analog controls.
        st_d.sw = ocp_switches(st_d.mode, st_d.gain);
        st_d.en = (st_d.mode != OCP_MODE_OFF);
        st_d.inv = (st_d.mode == OCP_MODE_INV);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Synchronous reset to the power-on values.
    // The switches rest in the off set, not at zero.
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            // Clear every field, then load the switch rest set.
            st_q <= '0;
            st_q.sw <= OCP_SW_S1_S3;
        end
        else
        begin
            // Take the next state on every edge.
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // All outputs are flip-flop fields of the state.
    assign reg_rdata_o = st_q.rdata;
    assign mode_switch_o = st_q.sw;
    assign analog_enable_o = st_q.en;
    assign amp_gain_code_o = st_q.gain;
    // The inverting flag is its own flop so no gate sits on the pin.
    assign amp_inverting_o = st_q.inv;
    assign threshold_code_o = st_q.thr;
    assign dac_ref_source_sel_o = st_q.dacref;
    assign amp_trim_mode_o = st_q.atrim[OCP_ATRIM_MODE_BIT];
    assign amp_trim_ref_sel_o = st_q.atrim[OCP_ATRIM_REF_BIT];
    assign amp_trim_value_o = st_q.atrim[5:0];
    assign cmp_trim_mode_o = st_q.ctrim[OCP_CTRIM_MODE_BIT];
    assign cmp_trim_ref_sel_o = st_q.ctrim[OCP_CTRIM_REF_BIT];
    assign cmp_trim_value_o = st_q.ctrim[4:0];
    assign protect_out_o = st_q.prot;
    assign pwm_block_o = st_q.prot;
    assign protect_irq_o = st_q.irq_flag;

endmodule : ocp_ctrl
`default_nettype wire

/* File: tb/ocp_ctrl_properties.sv */
// Concurrent checks on the ports of the over-current protection control block.
`timescale 1ns/100ps
`default_nettype none
module ocp_ctrl_properties
import ocp_pkg::*;
(
    // Clock, reset and register port.
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // Analog controls and results.
    input wire logic [3:0] mode_switch_o,
    input wire logic analog_enable_o,
    input wire logic [2:0] amp_gain_code_o,
    input wire logic amp_inverting_o,
    input wire logic protect_out_o,
    input wire logic pwm_block_o,
    input wire logic protect_irq_o
);
    // ------------------------------------------------------------
    // Sequences and properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    // A write of a given mode code.
    sequence s_wr_mode(logic [1:0] m);
        reg_wr_i && reg_addr_i == OCP_ADDR_MODE && reg_wdata_i[7:6] == m;
    endsequence
    // A read of a given register index.
    sequence s_rd(logic [2:0] a);
        reg_rd_i && reg_addr_i == a;
    endsequence
    property p_mode_off;
        s_wr_mode(2'h0) |=> mode_switch_o == 4'ha && !analog_enable_o;
    endproperty
    property p_mode_ninv;
        s_wr_mode(2'h1) |=> mode_switch_o == (amp_gain_code_o == 3'h0 ? 4'h1 : 4'h9) && analog_enable_o && !amp_inverting_o;
    endproperty
    property p_mode_inv;
        s_wr_mode(2'h2) |=> mode_switch_o == 4'h6 && analog_enable_o && amp_inverting_o;
    endproperty
    property p_mode_cal;
        s_wr_mode(2'h3) |=> mode_switch_o == 4'ha && analog_enable_o && !amp_inverting_o;
    endproperty
    property p_off_quiet;
        !analog_enable_o && !$past(analog_enable_o) |-> !protect_out_o;
    endproperty
    property p_pwm_follow;
        pwm_block_o == protect_out_o;
    endproperty
    property p_irq_set;
        $rose(protect_out_o) |-> ##1 protect_irq_o;
    endproperty
    property p_status_read;
        s_rd(OCP_ADDR_GAIN) |=> reg_rdata_o[7] == $past(protect_out_o) && reg_rdata_o[6] == 1'b0;
    endproperty
    property p_mode_low_zero;
        s_rd(OCP_ADDR_MODE) |=> reg_rdata_o[5:0] == 6'h00;
    endproperty
    property p_gain_write;
        reg_wr_i && reg_addr_i == OCP_ADDR_GAIN |=> amp_gain_code_o == $past(reg_wdata_i[5:3]);
    endproperty
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_mode_off: assert property (p_mode_off) else $error("mode off switches wrong");
    a_mode_ninv: assert property (p_mode_ninv) else $error("non-inverting switches wrong");
    a_mode_inv: assert property (p_mode_inv) else $error("inverting switches wrong");
    a_mode_cal: assert property (p_mode_cal) else $error("calibration switches wrong");
    a_off_quiet: assert property (p_off_quiet) else $error("protection high while off");
    a_pwm_follow: assert property (p_pwm_follow) else $error("pwm block differs");
    a_irq_set: assert property (p_irq_set) else $error("irq flag not set");
    a_status_read: assert property (p_status_read) else $error("status bit wrong");
    a_mode_low_zero: assert property (p_mode_low_zero) else $error("mode low bits not zero");
    a_gain_write: assert property (p_gain_write) else $error("gain code not taken");
endmodule : ocp_ctrl_properties
bind ocp_ctrl ocp_ctrl_properties ocp_ctrl_properties_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .mode_switch_o(mode_switch_o), .analog_enable_o(analog_enable_o),
    .amp_gain_code_o(amp_gain_code_o), .amp_inverting_o(amp_inverting_o), .protect_out_o(protect_out_o),
    .pwm_block_o(pwm_block_o), .protect_irq_o(protect_irq_o));
`default_nettype wire

/* File: tb/ocp_analog_model.sv */
// Behavioural model of the analog amplifier, comparator and trim readback.
`timescale 1ns/100ps
`default_nettype none
module ocp_analog_model
#(
    parameter logic [5:0] AMP_FLIP = 6'h15,  // Amplifier trim code where its output flips.
    parameter logic [4:0] CMP_FLIP = 5'h0a   // Comparator trim code where its output flips.
)
(
    // Controls from the block.
    input wire logic enable_i,
    input wire logic [7:0] threshold_i,
    input wire logic amp_trim_mode_i,
    input wire logic [5:0] amp_trim_value_i,
    input wire logic cmp_trim_mode_i,
    input wire logic [4:0] cmp_trim_value_i,
    // Sense level from the bench.
    input wire logic [7:0] sense_i,
    // Results back to the block.
    output logic cmp_o,
    output logic amp_o
);
    // Comparator is low when powered off; in trim mode it flips at the offset step.
    assign cmp_o = !enable_i ? 1'b0 : cmp_trim_mode_i ? (cmp_trim_value_i >= CMP_FLIP) : (sense_i > threshold_i);
    // Amplifier output flips once the trim cancels the offset.
    assign amp_o = enable_i && amp_trim_mode_i && (amp_trim_value_i >= AMP_FLIP);
endmodule : ocp_analog_model
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the over-current protection control block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import ocp_pkg::*;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [2:0] reg_addr_i = 3'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] sense_level = 8'h00;  // Analog sense level fed to the model.
    logic [7:0] reg_rdata_o, threshold_code_o, rd_val;
    logic [3:0] mode_switch_o;
    logic [2:0] amp_gain_code_o;
    logic [5:0] amp_trim_value_o;
    logic [4:0] cmp_trim_value_o;
    logic raw_cmp_result_i, amp_out_status_i, analog_enable_o, amp_inverting_o, dac_ref_source_sel_o;
    logic amp_trim_mode_o, amp_trim_ref_sel_o, cmp_trim_mode_o, cmp_trim_ref_sel_o;
    logic protect_out_o, pwm_block_o, protect_irq_o;
    int miscompares = 0;
    int num_checks = 0;
    // Write values and expected readback for indices 0 to 7.
    logic [7:0] wv [0:7] = '{8'hff, 8'hff, 8'hff, 8'h7f, 8'h3f, 8'hff, 8'h02, 8'hff};
    logic [7:0] ev [0:7] = '{8'hc0, 8'h3f, 8'hff, 8'h7f, 8'h3f, 8'h40, 8'h02, 8'h00};
    logic [3:0] sw [0:3] = '{4'ha, 4'h9, 4'h6, 4'ha};  // Switch sets per mode.
    int fk [0:3] = '{0, 1, 3, 7};  // Filter codes timed.
    always #50 sys_clk_i = ~sys_clk_i;
    ocp_ctrl ocp_ctrl_i (.*);
    ocp_analog_model ocp_analog_model_i (.enable_i(analog_enable_o), .threshold_i(threshold_code_o),
        .amp_trim_mode_i(amp_trim_mode_o), .amp_trim_value_i(amp_trim_value_o), .cmp_trim_mode_i(cmp_trim_mode_o),
        .cmp_trim_value_i(cmp_trim_value_o), .sense_i(sense_level), .cmp_o(raw_cmp_result_i), .amp_o(amp_out_status_i));
    // Compares one value and counts it.
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // Prints the counts and the verdict, then stops.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    // One-cycle register write; outputs are settled on return.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask : wr
    // One-cycle register read; data is taken in the following cycle.
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask : rd
    // Counts edges until the protection output reaches a level, bounded.
    task automatic wait_prot(input logic lvl, output int n);
        n = 0;
        while (protect_out_o !== lvl && n < 600)
        begin
            @(posedge sys_clk_i);
            #1 n++;
        end
        if (protect_out_o !== lvl) begin miscompares++; tally_and_finish(); end
    endtask : wait_prot
    // Sweeps a trim field upward and returns the first code with readback high.
    task automatic sweep(input logic [2:0] a, input logic [7:0] mode_bit, input int top, output int found);
        found = -1;
        for (int v = 0; v < top; v++)
        begin
            wr(a, mode_bit | 8'(v));
            repeat (3) @(posedge sys_clk_i);
            rd(OCP_ADDR_CTRIM, rd_val);
            if (rd_val[7] === 1'b1 && found < 0) found = v;
        end
        wr(a, 8'h00);
    endtask : sweep
    initial
    begin
        int n;
        int lo;
        repeat (20) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        for (int a = 0; a < 8; a++) begin rd(3'(a), rd_val); chk("reset value", rd_val, 8'h00); end
        for (int a = 0; a < 8; a++) begin wr(3'(a), wv[a]); rd(3'(a), rd_val); chk("readback", rd_val, ev[a]); end
        chk("threshold", threshold_code_o, 8'hff);
        chk("dac ref", {7'h0, dac_ref_source_sel_o}, 8'h01);
        chk("trims", {amp_trim_ref_sel_o, amp_trim_value_o, cmp_trim_ref_sel_o}, 8'hff);
        $display("test registers done");
        for (int g = 0; g < 8; g++) begin wr(OCP_ADDR_GAIN, {2'h0, 3'(g), 3'(g)}); chk("gain", {5'h0, amp_gain_code_o}, 8'(g)); end
        for (int m = 0; m < 4; m++)
        begin
            wr(OCP_ADDR_MODE, {2'(m), 6'h3f});
            chk("switches", {4'h0, mode_switch_o}, {4'h0, sw[m]});
            chk("enable", {6'h0, analog_enable_o, amp_inverting_o}, {6'h0, m != 0, m == 2});
        end
        wr(OCP_ADDR_GAIN, 8'h00);
        wr(OCP_ADDR_MODE, 8'h40);
        chk("unity switches", {4'h0, mode_switch_o}, 8'h01);
        $display("test modes done");
        wr(OCP_ADDR_THR, 8'h80);
        for (int i = 0; i < 4; i++)
        begin
            wr(OCP_ADDR_GAIN, {2'h0, 3'h1, 3'(fk[i])});
            lo = 4 * ((1 << fk[i]) - 1);
            @(posedge sys_clk_i);
            sense_level <= 8'h81;
            wait_prot(1'b1, n);
            chk("filter delay", {7'h0, n >= lo + (fk[i] == 0 ? 2 : -1) && n <= lo + (fk[i] == 0 ? 4 : 6)}, 8'h01);
            chk("pwm block", {7'h0, pwm_block_o}, 8'h01);
            rd(OCP_ADDR_IRQ, rd_val);
            chk("irq flag", rd_val, 8'h12);
            rd(OCP_ADDR_GAIN, rd_val);
            chk("status", rd_val, {2'h2, 3'h1, 3'(fk[i])});
            wr(OCP_ADDR_IRQ, 8'h02);
            chk("irq cleared", {7'h0, protect_irq_o}, 8'h00);
            sense_level <= 8'h00;
            wait_prot(1'b0, n);
        end
        @(posedge sys_clk_i);
        sense_level <= 8'h81;
        repeat (10) @(posedge sys_clk_i);
        sense_level <= 8'h00;
        repeat (40) @(posedge sys_clk_i);
        #1 chk("short pulse", {7'h0, protect_out_o}, 8'h00);
        wr(OCP_ADDR_GAIN, 8'h00);
        sense_level <= 8'h81;
        wait_prot(1'b1, n);
        wr(OCP_ADDR_MODE, 8'h00);
        @(posedge sys_clk_i);
        #1;
        chk("off forces low", {7'h0, protect_out_o}, 8'h00);
        sense_level <= 8'h00;
        $display("test filter done");
        wr(OCP_ADDR_MODE, 8'hc0);
        sweep(OCP_ADDR_ATRIM, 8'h80, 64, n);
        chk("amp trim flip", 8'(n), 8'h15);
        sweep(OCP_ADDR_CTRIM, 8'h40, 32, n);
        chk("cmp trim flip", 8'(n), 8'h0a);
        $display("test trim done");
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
